// file: shared/gpp_pkg.sv
package gpp_pkg;
  localparam int unsigned NPINS = 8;
  // output driver modes
  typedef enum logic [2:0] {
    GPP_TOTEM  = 3'h0,
    GPP_BUSKEEP = 3'h1,
    GPP_WOR    = 3'h2,
    GPP_WAND   = 3'h3
  } gpp_drive_t;
  // pull selection
  typedef enum logic [1:0] {
    GPP_PULL_NONE = 2'h0,
    GPP_PULL_DOWN = 2'h1,
    GPP_PULL_UP   = 2'h2
  } gpp_pull_t;
  // sense condition
  typedef enum logic [1:0] {
    GPP_SENSE_BOTH = 2'h0,
    GPP_SENSE_RISE = 2'h1,
    GPP_SENSE_FALL = 2'h2,
    GPP_SENSE_LOW  = 2'h3
  } gpp_sense_t;
  // pin write operations
  typedef enum logic [1:0] {
    GPP_OP_SET    = 2'h0,
    GPP_OP_CLR    = 2'h1,
    GPP_OP_TGL    = 2'h2,
    GPP_OP_WRITE  = 2'h3
  } gpp_op_t;
  // clock/event routing select
  typedef enum logic [1:0] {
    GPP_ROUTE_NONE = 2'h0,
    GPP_ROUTE_PER  = 2'h1,
    GPP_ROUTE_RTC  = 2'h2,
    GPP_ROUTE_EVT  = 2'h3
  } gpp_route_t;
  localparam logic [7:0] GPP_RST_BYTE = 8'h00;
  localparam logic [2:0] GPP_RST_CFG  = 3'h0;
  localparam logic [1:0] GPP_RST_2B   = 2'h0;
  localparam logic [2:0] GPP_RST_PIN  = 3'h0;
  localparam logic       GPP_RST_BIT  = 1'b0;
endpackage : gpp_pkg

// file: rtl/gpp_pin_sense.sv
`timescale 1ns/10ps
`default_nettype none
// per-pin synchroniser and condition detector
module gpp_pin_sense (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              pin_in,
  input  wire logic              invert,
  input  wire gpp_pkg::gpp_sense_t sense,
  output logic                   sync_val,
  output logic                   hit
);
  import gpp_pkg::*;
  logic meta_r, meta_nxt, sync_r, sync_nxt, prev_r, prev_nxt;
  logic inv_pin;

  always_comb begin
    inv_pin  = pin_in ^ invert;
    meta_nxt = inv_pin;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_r <= GPP_RST_BIT;
      sync_r <= GPP_RST_BIT;
      prev_r <= GPP_RST_BIT;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  always_comb begin
    case (sense)
      GPP_SENSE_BOTH: hit = sync_r ^ prev_r;
      GPP_SENSE_RISE: hit = sync_r & ~prev_r;
      GPP_SENSE_FALL: hit = ~sync_r & prev_r;
      GPP_SENSE_LOW:  hit = ~sync_r;
      default:        hit = 1'b0;
    endcase
  end
  assign sync_val = sync_r;

  a_rise_hit: assert property (@(posedge ref_clk)
    disable iff (!reset_n) (sense == GPP_SENSE_RISE && $rose(sync_r)) |-> hit)
    else $error("rising edge missed");
  a_sync_delay: assert property (@(posedge ref_clk)
    disable iff (!reset_n) $past(reset_n, 2) |-> sync_r == $past(inv_pin, 2))
    else $error("synchroniser depth wrong");
endmodule : gpp_pin_sense
`default_nettype wire

// file: rtl/gpp_port.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - eight pins, each individually input or output
// - per-pin totem, wired-and/or, keeper, inverted
// - optional pull on inputs and wired modes
// - keeper weakly holds last driven level
// - inverted pins invert before sensing
// - sync sensing with clock, async otherwise
// - edges or low level raise interrupts, events
// - async pin change wakes from sleep
// - two port interrupts with own masks
// - set, clear, toggle touch only one-bits
// - direction change leaves other pins alone
// - one config write hits many pins
// - enabled peripheral overrides pin function
// - clocks and events routable to pins
module gpp_port (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // pin side
  input  wire logic [7:0]           pin_in,
  output logic      [7:0]           pin_out,
  output logic      [7:0]           pin_oe,
  output logic      [7:0]           pin_pull_up,
  output logic      [7:0]           pin_pull_dn,
  // software side
  input  wire logic                 out_wr,
  input  wire gpp_pkg::gpp_op_t     out_op,
  input  wire logic [7:0]           out_data,
  input  wire logic                 dir_wr,
  input  wire gpp_pkg::gpp_op_t     dir_op,
  input  wire logic [7:0]           dir_data,
  input  wire logic                 cfg_wr,
  input  wire logic [7:0]           cfg_sel,
  input  wire gpp_pkg::gpp_drive_t  cfg_drive,
  input  wire gpp_pkg::gpp_pull_t   cfg_pull,
  input  wire logic                 cfg_invert,
  input  wire gpp_pkg::gpp_sense_t  cfg_sense,
  input  wire logic [7:0]           int0_mask,
  input  wire logic [7:0]           int1_mask,
  input  wire logic                 clk_enabled,
  input  wire logic [7:0]           flag_clr,
  output logic      [7:0]           out_val,
  output logic      [7:0]           dir_val,
  output logic      [7:0]           in_val,
  output logic      [7:0]           flags,
  output logic                      irq0,
  output logic                      irq1,
  output logic      [7:0]           sense_evt,
  output logic                      wake,
  // peripheral override and routing
  input  wire logic [7:0]           ovr_en,
  input  wire logic [7:0]           ovr_out,
  input  wire logic [7:0]           ovr_oe,
  input  wire logic                 per_clk_in,
  input  wire logic                 rtc_clk_in,
  input  wire logic                 evt_in,
  input  wire gpp_pkg::gpp_route_t  route_sel,
  input  wire logic [2:0]           route_pin
);
  import gpp_pkg::*;

  logic [7:0] out_r, out_nxt, dir_r, dir_nxt, keep_r, keep_nxt;
  logic [7:0] flag_r, flag_nxt;
  gpp_drive_t drive_r [8];
  gpp_drive_t drive_nxt [8];
  gpp_pull_t  pull_r [8];
  gpp_pull_t  pull_nxt [8];
  gpp_sense_t sense_r [8];
  gpp_sense_t sense_nxt [8];
  logic [7:0] inv_r, inv_nxt;
  logic [7:0] sync_v, hit_v, async_hit, drv_val, drv_oe;
  logic       route_val;

  function automatic logic [7:0] apply_op(input gpp_op_t op,
                                          input logic [7:0] cur,
                                          input logic [7:0] d);
    case (op)
      GPP_OP_SET: apply_op = cur | d;
      GPP_OP_CLR: apply_op = cur & ~d;
      GPP_OP_TGL: apply_op = cur ^ d;
      default:    apply_op = d;
    endcase
  endfunction : apply_op

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      gpp_pin_sense u_sense (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .pin_in   (pin_in[g]),
        .invert   (inv_r[g]),
        .sense    (sense_r[g]),
        .sync_val (sync_v[g]),
        .hit      (hit_v[g])
      );
    end
  endgenerate

  // configuration and pin state
  always_comb begin
    out_nxt = out_wr ? apply_op(out_op, out_r, out_data)
                     : out_r;
    dir_nxt = dir_wr ? apply_op(dir_op, dir_r, dir_data)
                     : dir_r;
    inv_nxt = inv_r;
    for (int i = 0; i < 8; i++) begin
      drive_nxt[i] = drive_r[i];
      pull_nxt[i]  = pull_r[i];
      sense_nxt[i] = sense_r[i];
      if (cfg_wr && cfg_sel[i]) begin
        drive_nxt[i] = cfg_drive;
        pull_nxt[i]  = cfg_pull;
        sense_nxt[i] = cfg_sense;
        inv_nxt[i]   = cfg_invert;
      end
    end
  end

  // route select and driven value
  always_comb begin
    case (route_sel)
      GPP_ROUTE_PER: route_val = per_clk_in;
      GPP_ROUTE_RTC: route_val = rtc_clk_in;
      GPP_ROUTE_EVT: route_val = evt_in;
      default:       route_val = 1'b0;
    endcase
    for (int i = 0; i < 8; i++) begin
      drv_val[i] = out_r[i] ^ inv_r[i];
      drv_oe[i]  = dir_r[i];
      if (route_sel != GPP_ROUTE_NONE && route_pin == i[2:0]) begin
        drv_val[i] = route_val;
        drv_oe[i]  = 1'b1;
      end
      if (ovr_en[i]) begin
        drv_val[i] = ovr_out[i];
        drv_oe[i]  = ovr_oe[i];
      end
    end
  end

  // pin drivers, pulls and keeper
  always_comb begin
    keep_nxt = keep_r;
    for (int i = 0; i < 8; i++) begin
      pin_out[i]     = drv_val[i];
      pin_oe[i]      = drv_oe[i];
      pin_pull_up[i] = 1'b0;
      pin_pull_dn[i] = 1'b0;
      case (drive_r[i])
        GPP_WOR:  pin_oe[i] = drv_oe[i] & drv_val[i];
        GPP_WAND: pin_oe[i] = drv_oe[i] & ~drv_val[i];
        default:  pin_oe[i] = drv_oe[i];
      endcase
      if (drv_oe[i]) keep_nxt[i] = drv_val[i];
      if (drive_r[i] == GPP_BUSKEEP && !pin_oe[i]) begin
        pin_pull_up[i] = keep_r[i];
        pin_pull_dn[i] = ~keep_r[i];
      end else if (!pin_oe[i] || drive_r[i] == GPP_WOR
                   || drive_r[i] == GPP_WAND) begin
        pin_pull_up[i] = (pull_r[i] == GPP_PULL_UP);
        pin_pull_dn[i] = (pull_r[i] == GPP_PULL_DOWN);
      end
    end
  end

  // async sensing: combinational, no clock needed
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (sense_r[i])
        GPP_SENSE_LOW: async_hit[i] = ~(pin_in[i] ^ inv_r[i]);
        default:       async_hit[i] = (pin_in[i] ^ inv_r[i]) ^ sync_v[i];
      endcase
    end
  end

  // sticky flags: set wins over clear
  always_comb begin
    flag_nxt = (flag_r & ~flag_clr) | (clk_enabled ? hit_v : 8'h00);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      out_r  <= GPP_RST_BYTE;
      dir_r  <= GPP_RST_BYTE;
      keep_r <= GPP_RST_BYTE;
      inv_r  <= GPP_RST_BYTE;
      flag_r <= GPP_RST_BYTE;
      for (int i = 0; i < 8; i++) begin
        drive_r[i] <= GPP_TOTEM;
        pull_r[i]  <= GPP_PULL_NONE;
        sense_r[i] <= GPP_SENSE_BOTH;
      end
    end else begin
      out_r  <= out_nxt;
      dir_r  <= dir_nxt;
      keep_r <= keep_nxt;
      inv_r  <= inv_nxt;
      flag_r <= flag_nxt;
      for (int i = 0; i < 8; i++) begin
        drive_r[i] <= drive_nxt[i];
        pull_r[i]  <= pull_nxt[i];
        sense_r[i] <= sense_nxt[i];
      end
    end
  end

  assign out_val   = out_r;
  assign dir_val   = dir_r;
  assign in_val    = sync_v;
  assign flags     = flag_r;
  assign irq0      = |(flag_r & int0_mask);
  assign irq1      = |(flag_r & int1_mask);
  assign sense_evt = clk_enabled ? hit_v : 8'h00;
  assign wake      = ~clk_enabled & |async_hit;

  a_set_only: assert property (@(posedge ref_clk)
    disable iff (!reset_n) (out_wr && out_op == GPP_OP_SET)
    |=> out_r == ($past(out_r) | $past(out_data)))
    else $error("set op wrong");
  a_clr_only: assert property (@(posedge ref_clk)
    disable iff (!reset_n) (out_wr && out_op == GPP_OP_CLR)
    |=> out_r == ($past(out_r) & ~$past(out_data)))
    else $error("clear op wrong");
  a_dir_others: assert property (@(posedge ref_clk)
    disable iff (!reset_n) (dir_wr && dir_op != GPP_OP_WRITE)
    |=> ((dir_r ^ $past(dir_r)) & ~$past(dir_data)) == 8'h00)
    else $error("direction disturbed");
  a_irq_mask: assert property (@(posedge ref_clk)
    disable iff (!reset_n) ((flag_r & int0_mask) == 8'h00) |-> !irq0)
    else $error("masked irq");
  a_flag_set: assert property (@(posedge ref_clk)
    disable iff (!reset_n) (clk_enabled && hit_v[0]) |=> flag_r[0])
    else $error("flag lost");
  a_ovr_wins: assert property (@(posedge ref_clk)
    disable iff (!reset_n) (ovr_en[0] && drive_r[0] == GPP_TOTEM)
    |-> pin_oe[0] == ovr_oe[0])
    else $error("override ignored");
  a_cfg_multi: assert property (@(posedge ref_clk)
    disable iff (!reset_n) (cfg_wr && cfg_sel[3])
    |=> inv_r[3] == $past(cfg_invert))
    else $error("multi config missed");
  a_no_sync_off: assert property (@(posedge ref_clk)
    disable iff (!reset_n) !clk_enabled
    |=> (flag_r & ~$past(flag_r)) == 8'h00)
    else $error("sync flag set with clock off");

  c_irq0: cover property (@(posedge ref_clk) disable iff (!reset_n) irq0);
  c_irq1: cover property (@(posedge ref_clk) disable iff (!reset_n) irq1);
  c_wake: cover property (@(posedge ref_clk) disable iff (!reset_n) wake);
  c_route: cover property (@(posedge ref_clk) disable iff (!reset_n)
    route_sel == GPP_ROUTE_RTC && pin_oe[route_pin]);
endmodule : gpp_port
`default_nettype wire

// file: verification/gpp_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// outside circuitry: drives a pin the port has released, else the pulls win
module gpp_pin_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up,
  input  wire logic [7:0] pin_pull_dn,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge ref_clk) begin
    last_r <= pin_in;
  end
  // a floating pin shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'b1;
      else if (pin_pull_dn[i]) pin_in[i] = 1'b0;
      else pin_in[i] = ~last_r[i];
    end
  end
endmodule : gpp_pin_model
`default_nettype wire

// file: verification/general_purpose_io_port_test.sv
`timescale 1ns/10ps
`default_nettype none
module general_purpose_io_port_test;
  import gpp_pkg::*;
  logic       ref_clk = 1'b0, reset_n = 1'b0;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_dn;
  logic       out_wr = 1'b0, dir_wr = 1'b0, cfg_wr = 1'b0;
  gpp_op_t    out_op = GPP_OP_SET, dir_op = GPP_OP_SET;
  logic [7:0] out_data = 8'h00, dir_data = 8'h00, cfg_sel = 8'h00;
  gpp_drive_t cfg_drive = GPP_TOTEM;
  gpp_pull_t  cfg_pull = GPP_PULL_NONE;
  logic       cfg_invert = 1'b0, clk_enabled = 1'b1;
  gpp_sense_t cfg_sense = GPP_SENSE_BOTH;
  logic [7:0] int0_mask = 8'h08, int1_mask = 8'h10, flag_clr = 8'h00;
  logic [7:0] out_val, dir_val, in_val, flags, sense_evt;
  logic       irq0, irq1, wake;
  logic [7:0] ovr_en = 8'h00, ovr_out = 8'h00, ovr_oe = 8'h00;
  logic       per_clk_in = 1'b0, rtc_clk_in = 1'b0, evt_in = 1'b0;
  gpp_route_t route_sel = GPP_ROUTE_NONE;
  logic [2:0] route_pin = 3'h5;
  logic [7:0] ext_en = 8'hff, ext_val = 8'h08;
  logic [4:0] exp_f = 5'b11101, exp_r = 5'b01011, exp_l = 5'b01000;
  int         errors = 0, n_compared = 0;

  gpp_port dut_u (.ref_clk, .reset_n, .pin_in, .pin_out, .pin_oe,
    .pin_pull_up, .pin_pull_dn, .out_wr, .out_op, .out_data, .dir_wr,
    .dir_op, .dir_data, .cfg_wr, .cfg_sel, .cfg_drive, .cfg_pull,
    .cfg_invert, .cfg_sense, .int0_mask, .int1_mask, .clk_enabled,
    .flag_clr, .out_val, .dir_val, .in_val, .flags, .irq0, .irq1,
    .sense_evt, .wake, .ovr_en, .ovr_out, .ovr_oe, .per_clk_in,
    .rtc_clk_in, .evt_in, .route_sel, .route_pin);
  gpp_pin_model far_u (.ref_clk, .pin_out, .pin_oe, .pin_pull_up,
    .pin_pull_dn, .ext_en, .ext_val, .pin_in);

  always #5 ref_clk = ~ref_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic is_dir, input gpp_op_t op,
                    input logic [7:0] d);
    @(posedge ref_clk);
    out_wr <= !is_dir;
    dir_wr <= is_dir;
    out_op <= op;
    dir_op <= op;
    out_data <= d;
    dir_data <= d;
    @(posedge ref_clk);
    out_wr <= 1'b0;
    dir_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic cfg(input logic [7:0] sel, input gpp_drive_t dr,
                     input gpp_pull_t pl, input logic inv,
                     input gpp_sense_t se);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_sel <= sel;
    cfg_drive <= dr;
    cfg_pull <= pl;
    cfg_invert <= inv;
    cfg_sense <= se;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    #1;
  endtask : cfg

  // new pin level with an optional flag clear, then let sensing settle
  task automatic step(input logic [7:0] v, input logic [7:0] clr);
    @(posedge ref_clk);
    ext_val <= v;
    flag_clr <= clr;
    @(posedge ref_clk);
    flag_clr <= 8'h00;
    tick(4);
  endtask : step

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    tick(1);
    check(out_val, GPP_RST_BYTE, "out reset");
    check(pin_oe, 8'h00, "oe reset");
    wr(1'b0, GPP_OP_WRITE, 8'h5a);
    check(out_val, 8'h5a, "out write");
    wr(1'b0, GPP_OP_SET, 8'h81);
    check(out_val, 8'hdb, "out set");
    wr(1'b0, GPP_OP_CLR, 8'h0a);
    check(out_val, 8'hd1, "out clr");
    wr(1'b0, GPP_OP_TGL, 8'hff);
    check(out_val, 8'h2e, "out tgl");
    wr(1'b1, GPP_OP_SET, 8'h01);
    wr(1'b1, GPP_OP_SET, 8'h02);
    check(dir_val, 8'h03, "dir set");
    wr(1'b1, GPP_OP_CLR, 8'h01);
    check(dir_val, 8'h02, "dir clr");
    check(pin_oe, 8'h02, "oe totem");
    check(pin_out & pin_oe, 8'h02, "out totem");
    $display("test rmw done");
    wr(1'b1, GPP_OP_WRITE, 8'hff);
    cfg(8'hf0, GPP_WOR, GPP_PULL_NONE, 1'b0, GPP_SENSE_BOTH);
    check(pin_oe, 8'h2f, "oe wor");
    cfg(8'hf0, GPP_WAND, GPP_PULL_NONE, 1'b0, GPP_SENSE_BOTH);
    check(pin_oe, 8'hdf, "oe wand");
    cfg(8'hff, GPP_BUSKEEP, GPP_PULL_NONE, 1'b0,
        GPP_SENSE_BOTH);
    wr(1'b1, GPP_OP_WRITE, 8'h00);
    tick(1);
    check(pin_pull_up, 8'h2e, "keeper up");
    check(pin_pull_dn, 8'hd1, "keeper down");
    cfg(8'hff, GPP_TOTEM, GPP_PULL_UP, 1'b0, GPP_SENSE_BOTH);
    check(pin_pull_up, 8'hff, "pull up");
    cfg(8'hff, GPP_WOR, GPP_PULL_DOWN, 1'b0, GPP_SENSE_BOTH);
    check(pin_pull_dn, 8'hff, "pull down");
    $display("test drive done");
    // modes 0..3 plain, mode 4 is rising sense on an inverted pin
    for (int m = 0; m < 5; m++) begin
      cfg(8'hff, GPP_TOTEM, GPP_PULL_NONE, m == 4,
          m == 4 ? GPP_SENSE_RISE : gpp_sense_t'(2'(m)));
      tick(3);
      step(8'h08, 8'hff);
      step(8'h00, 8'h00);
      check({7'h00, flags[3]}, {7'h00, exp_f[m]}, "fall");
      check({6'h00, irq1, irq0}, {6'h00, exp_l[m], exp_f[m]},
            "irq");
      check({7'h00, sense_evt[3]}, {7'h00, exp_l[m]}, "evt");
      step(8'h00, 8'hff);
      step(8'h08, 8'h00);
      check({7'h00, flags[3]}, {7'h00, exp_r[m]}, "rise");
      check(in_val & 8'h08, m == 4 ? 8'h00 : 8'h08, "in");
    end
    $display("test sense done");
    @(posedge ref_clk);
    clk_enabled <= 1'b0;
    tick(3);
    @(posedge ref_clk);
    ext_val <= 8'h00;
    #1;
    check({7'h00, wake}, 8'h01, "wake");
    @(posedge ref_clk);
    clk_enabled <= 1'b1;
    ovr_en <= 8'h01;
    ovr_out <= 8'h01;
    ovr_oe <= 8'h01;
    tick(2);
    check(pin_oe & pin_out & 8'h01, 8'h01, "override");
    for (int r = 1; r < 4; r++) begin
      @(posedge ref_clk);
      route_sel <= gpp_route_t'(2'(r));
      per_clk_in <= r == 1;
      rtc_clk_in <= r == 2;
      evt_in <= r == 3;
      tick(2);
      check(pin_oe & pin_out & 8'h20, 8'h20, "route");
    end
    $display("test route done");
    finish_test();
  end
endmodule : general_purpose_io_port_test
`default_nettype wire
